//--- src/oss_map.vh
// Behaviour
// - Codes 0-99 positive, 100-199 negative logic.
// - Any condition routes to terminal or link.
// - Running when frequency at/above starting frequency.
// - Frequency reached when output within tolerance of a nonzero set frequency.
// - Overload alarm while stall prevention active.
// - Frequency detect uses separate reverse threshold.
// - Regen pre-alarm at 85% allowed duty.
// - Thermal pre-alarm 85%, trip at 100%.
// - Ready after reset, while startable or running.
// - Current detect after high level persists.
// - Zero current after low level persists.
// - Lower limit when feedback below limit.
// - Upper limit when feedback above limit.
// - Direction output while loop drives forward.
// - Brake open request when sequence opens brake.
// - Fan fault indication on fan fault.
// - Heatsink pre-alarm near 85% overheat temperature.
// - Power-fail decel latched until released.
// - Loop active while process control operates.
// - Active condition conducts positive, not negative.
`ifndef OSS_MAP_VH
`define OSS_MAP_VH
`define OSS_NUM_TERM     6
`define OSS_NEG_BASE     8'h64
`define OSS_CODE_MAX     8'hc7
`define OSS_NONE_CODE    14'h270f
`define OSS_CODE_RUN     7'h00
`define OSS_CODE_REACH   7'h01
`define OSS_CODE_OVL     7'h03
`define OSS_CODE_FDET    7'h04
`define OSS_CODE_RBPA    7'h07
`define OSS_CODE_THPA    7'h08
`define OSS_CODE_READY   7'h0b
`define OSS_CODE_IDET    7'h0c
`define OSS_CODE_ZDET    7'h0d
`define OSS_CODE_LLIM    7'h0e
`define OSS_CODE_ULIM    7'h0f
`define OSS_CODE_LDIR    7'h10
`define OSS_CODE_BRK     7'h14
`define OSS_CODE_FAN     7'h19
`define OSS_CODE_HSPA    7'h1a
`define OSS_CODE_PFD     7'h2e
`define OSS_CODE_LACT    7'h2f
`define OSS_PREALARM_PCT 8'h55
`define OSS_TRIP_PCT     8'h64
`define OSS_ZERO_TERM    0
`endif

//--- src/oss_term_sel.v
`timescale 1ns/1ps
`default_nettype none
`include "oss_map.vh"
module oss_term_sel (
    input  wire        clk,
    input  wire        rst,
    input  wire [13:0] sel_code,
    input  wire [16:0] cond,
    output reg         term_on
);
    reg  [6:0] base;
    reg  [7:0] diff;
    reg        known;
    reg        neg;
    reg        valid;
    reg        act;
    reg        term_next;
    always @* begin
        neg   = 1'b0;
        base  = 7'h00;
        valid = 1'b0;
        known = 1'b1;
        // Negative codes reach 199, so the offset is removed on eight bits.
        diff  = sel_code[7:0] - `OSS_NEG_BASE;
        if (sel_code <= {6'h00, `OSS_CODE_MAX}) begin
            valid = 1'b1;
            if (sel_code >= {6'h00, `OSS_NEG_BASE}) begin
                neg  = 1'b1;
                base = diff[6:0];
            end else begin
                base = sel_code[6:0];
            end
        end
        case (base)
            `OSS_CODE_RUN:   act = cond[0];
            `OSS_CODE_REACH: act = cond[1];
            `OSS_CODE_OVL:   act = cond[2];
            `OSS_CODE_FDET:  act = cond[3];
            `OSS_CODE_RBPA:  act = cond[4];
            `OSS_CODE_THPA:  act = cond[5];
            `OSS_CODE_READY: act = cond[6];
            `OSS_CODE_IDET:  act = cond[7];
            `OSS_CODE_ZDET:  act = cond[8];
            `OSS_CODE_LLIM:  act = cond[9];
            `OSS_CODE_ULIM:  act = cond[10];
            `OSS_CODE_LDIR:  act = cond[11];
            `OSS_CODE_BRK:   act = cond[12];
            `OSS_CODE_FAN:   act = cond[13];
            `OSS_CODE_HSPA:  act = cond[14];
            `OSS_CODE_PFD:   act = cond[15];
            `OSS_CODE_LACT:  act = cond[16];
            default: begin
                act   = 1'b0;
                known = 1'b0;
            end
        endcase
        // Unassigned codes leave the terminal off in either polarity.
        term_next = valid & known & (act ^ neg) & (cond[6] | ~neg | act);
        if (!valid) begin
            term_next = 1'b0;
        end
    end
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            term_on <= 1'b0;
        end else begin
            term_on <= term_next;
        end
    end
endmodule
`default_nettype wire

//--- src/oss_selector.v
`timescale 1ns/1ps
`default_nettype none
`include "oss_map.vh"
module oss_selector (
    input  wire        MCLK,
    input  wire        RST,
    input  wire [13:0] SEL_CODE_0,
    input  wire [13:0] SEL_CODE_1,
    input  wire [13:0] SEL_CODE_2,
    input  wire [13:0] SEL_CODE_3,
    input  wire [13:0] SEL_CODE_4,
    input  wire [13:0] SEL_CODE_5,
    input  wire [15:0] OUT_FREQ,
    input  wire [15:0] START_FREQ,
    input  wire [15:0] SET_FREQ,
    input  wire [15:0] FREQ_TOL,
    input  wire        REVERSE,
    input  wire [15:0] FDET_FWD_LEVEL,
    input  wire [15:0] FDET_REV_LEVEL,
    input  wire        STALL_ACTIVE,
    input  wire [7:0]  REGEN_DUTY_PCT,
    input  wire [7:0]  THERMAL_PCT,
    input  wire        RESET_DONE,
    input  wire        STARTABLE,
    input  wire [15:0] OUT_CURRENT,
    input  wire [15:0] IDET_LEVEL,
    input  wire [15:0] IDET_TIME,
    input  wire [15:0] OUT_POWER,
    input  wire [15:0] ZDET_LEVEL,
    input  wire [15:0] ZDET_TIME,
    input  wire        LOOP_ENABLE,
    input  wire [15:0] LOOP_FEEDBACK,
    input  wire [15:0] LOOP_LOW_LIMIT,
    input  wire [15:0] LOOP_HIGH_LIMIT,
    input  wire        LOOP_FORWARD,
    input  wire        BRAKE_SEQ_EN,
    input  wire        BRAKE_OPEN_CMD,
    input  wire        FAN_FAULT,
    input  wire [7:0]  HEATSINK_PCT,
    input  wire        PF_DECEL_RUN,
    input  wire        PF_RELEASE,
    output wire        OPEN_COLLECTOR_OUTPUT,
    output wire [4:0]  LINK_OUT,
    output reg         THERMAL_TRIP_FAULT,
    output wire [16:0] COND_STATE
);
    reg         run_reg;
    reg         freq_reached_reg;
    reg         overload_alarm_reg;
    reg         freq_detect_reg;
    reg         regen_brake_prealarm_reg;
    reg         thermal_prealarm_reg;
    reg         operation_ready_reg;
    reg         current_detect_reg;
    reg         zero_current_detect_reg;
    reg         loop_lower_limit_reg;
    reg         loop_upper_limit_reg;
    reg         loop_direction_out_reg;
    reg         brake_open_request_reg;
    reg         fan_fault_reg;
    reg         heatsink_prealarm_reg;
    reg         power_fail_decel_reg;
    reg         loop_active_reg;
    wire        run_next;
    wire        freq_reached_next;
    wire        overload_alarm_next;
    wire        freq_detect_next;
    wire        regen_brake_prealarm_next;
    wire        thermal_prealarm_next;
    wire        operation_ready_next;
    wire        current_detect_next;
    wire        zero_current_detect_next;
    wire        loop_lower_limit_next;
    wire        loop_upper_limit_next;
    wire        loop_direction_out_next;
    wire        brake_open_request_next;
    wire        fan_fault_next;
    wire        heatsink_prealarm_next;
    wire        power_fail_decel_next;
    wire        loop_active_next;
    wire        trip_next;
    wire [16:0] cond_vec;
    reg  [15:0] idet_cnt_reg;
    reg  [15:0] zdet_cnt_reg;
    reg         pfd_reg;
    reg  [15:0] fdet_level;
    reg  [15:0] freq_diff;
    wire [83:0] sel_all;
    wire [5:0]  term_on;
    wire        idet_over;
    wire        zdet_under;

    assign sel_all = {SEL_CODE_5, SEL_CODE_4, SEL_CODE_3,
                      SEL_CODE_2, SEL_CODE_1, SEL_CODE_0};
    assign idet_over  = OUT_CURRENT > IDET_LEVEL;
    assign zdet_under = OUT_POWER < ZDET_LEVEL;

    // Persistence timers saturate so a long condition never wraps off.
    always @(posedge MCLK or posedge RST) begin
        if (RST) begin
            idet_cnt_reg <= 16'h0000;
            zdet_cnt_reg <= 16'h0000;
        end else begin
            if (!idet_over) begin
                idet_cnt_reg <= 16'h0000;
            end else if (idet_cnt_reg != 16'hffff) begin
                idet_cnt_reg <= idet_cnt_reg + 16'h0001;
            end
            if (!zdet_under) begin
                zdet_cnt_reg <= 16'h0000;
            end else if (zdet_cnt_reg != 16'hffff) begin
                zdet_cnt_reg <= zdet_cnt_reg + 16'h0001;
            end
        end
    end

    // A new deceleration event wins over a release in the same cycle.
    always @(posedge MCLK or posedge RST) begin
        if (RST) begin
            pfd_reg <= 1'b0;
        end else if (PF_DECEL_RUN) begin
            pfd_reg <= 1'b1;
        end else if (PF_RELEASE) begin
            pfd_reg <= 1'b0;
        end
    end

    // The detect level follows the present rotation direction.
    always @* begin
        fdet_level = REVERSE ? FDET_REV_LEVEL : FDET_FWD_LEVEL;
    end

    // An absolute difference keeps the reached window symmetric about the set point.
    always @* begin
        if (OUT_FREQ > SET_FREQ) begin
            freq_diff = OUT_FREQ - SET_FREQ;
        end else begin
            freq_diff = SET_FREQ - OUT_FREQ;
        end
    end

    // Frequency conditions compare live values with no filtering.
    assign run_next = OUT_FREQ >= START_FREQ;
    assign freq_reached_next = (SET_FREQ != 16'h0000) && (freq_diff <= FREQ_TOL);
    assign freq_detect_next = OUT_FREQ >= fdet_level;

    // Protection conditions; the trip term keeps itself until reset.
    assign overload_alarm_next = STALL_ACTIVE;
    assign regen_brake_prealarm_next = REGEN_DUTY_PCT >= `OSS_PREALARM_PCT;
    assign thermal_prealarm_next = THERMAL_PCT >= `OSS_PREALARM_PCT;
    assign heatsink_prealarm_next = HEATSINK_PCT >= `OSS_PREALARM_PCT;
    assign fan_fault_next = FAN_FAULT;
    assign trip_next = THERMAL_TRIP_FAULT | (THERMAL_PCT >= `OSS_TRIP_PCT);

    // Readiness and the two persistence-filtered current conditions.
    assign operation_ready_next = RESET_DONE & (STARTABLE | run_next);
    assign current_detect_next = idet_over && (idet_cnt_reg > IDET_TIME);
    assign zero_current_detect_next = zdet_under && (zdet_cnt_reg > ZDET_TIME);

    // Loop conditions are only meaningful while process control runs.
    assign loop_lower_limit_next = LOOP_ENABLE && (LOOP_FEEDBACK < LOOP_LOW_LIMIT);
    assign loop_upper_limit_next = LOOP_ENABLE && (LOOP_FEEDBACK > LOOP_HIGH_LIMIT);
    assign loop_direction_out_next = LOOP_ENABLE & LOOP_FORWARD;
    assign loop_active_next = LOOP_ENABLE;

    // Sequence conditions; the event input is folded in so the first cycle is not lost.
    assign brake_open_request_next = BRAKE_SEQ_EN & BRAKE_OPEN_CMD;
    assign power_fail_decel_next = pfd_reg | PF_DECEL_RUN;

    // Each condition has its own flop so a terminal sees one stable level per cycle.
    always @(posedge MCLK or posedge RST) begin
        if (RST) begin
            run_reg <= 1'b0;
        end else begin
            run_reg <= run_next;
        end
    end

    always @(posedge MCLK or posedge RST) begin
        if (RST) begin
            freq_reached_reg <= 1'b0;
        end else begin
            freq_reached_reg <= freq_reached_next;
        end
    end

    always @(posedge MCLK or posedge RST) begin
        if (RST) begin
            freq_detect_reg <= 1'b0;
        end else begin
            freq_detect_reg <= freq_detect_next;
        end
    end

    // Protection flags.
    always @(posedge MCLK or posedge RST) begin
        if (RST) begin
            overload_alarm_reg <= 1'b0;
        end else begin
            overload_alarm_reg <= overload_alarm_next;
        end
    end

    always @(posedge MCLK or posedge RST) begin
        if (RST) begin
            regen_brake_prealarm_reg <= 1'b0;
        end else begin
            regen_brake_prealarm_reg <= regen_brake_prealarm_next;
        end
    end

    always @(posedge MCLK or posedge RST) begin
        if (RST) begin
            thermal_prealarm_reg <= 1'b0;
        end else begin
            thermal_prealarm_reg <= thermal_prealarm_next;
        end
    end

    always @(posedge MCLK or posedge RST) begin
        if (RST) begin
            heatsink_prealarm_reg <= 1'b0;
        end else begin
            heatsink_prealarm_reg <= heatsink_prealarm_next;
        end
    end

    always @(posedge MCLK or posedge RST) begin
        if (RST) begin
            fan_fault_reg <= 1'b0;
        end else begin
            fan_fault_reg <= fan_fault_next;
        end
    end

    always @(posedge MCLK or posedge RST) begin
        if (RST) begin
            THERMAL_TRIP_FAULT <= 1'b0;
        end else begin
            THERMAL_TRIP_FAULT <= trip_next;
        end
    end

    // Readiness and current detection flags.
    always @(posedge MCLK or posedge RST) begin
        if (RST) begin
            operation_ready_reg <= 1'b0;
        end else begin
            operation_ready_reg <= operation_ready_next;
        end
    end

    always @(posedge MCLK or posedge RST) begin
        if (RST) begin
            current_detect_reg <= 1'b0;
        end else begin
            current_detect_reg <= current_detect_next;
        end
    end

    always @(posedge MCLK or posedge RST) begin
        if (RST) begin
            zero_current_detect_reg <= 1'b0;
        end else begin
            zero_current_detect_reg <= zero_current_detect_next;
        end
    end

    // Process loop flags.
    always @(posedge MCLK or posedge RST) begin
        if (RST) begin
            loop_lower_limit_reg <= 1'b0;
        end else begin
            loop_lower_limit_reg <= loop_lower_limit_next;
        end
    end

    always @(posedge MCLK or posedge RST) begin
        if (RST) begin
            loop_upper_limit_reg <= 1'b0;
        end else begin
            loop_upper_limit_reg <= loop_upper_limit_next;
        end
    end

    always @(posedge MCLK or posedge RST) begin
        if (RST) begin
            loop_direction_out_reg <= 1'b0;
        end else begin
            loop_direction_out_reg <= loop_direction_out_next;
        end
    end

    always @(posedge MCLK or posedge RST) begin
        if (RST) begin
            loop_active_reg <= 1'b0;
        end else begin
            loop_active_reg <= loop_active_next;
        end
    end

    // Sequence flags.
    always @(posedge MCLK or posedge RST) begin
        if (RST) begin
            brake_open_request_reg <= 1'b0;
        end else begin
            brake_open_request_reg <= brake_open_request_next;
        end
    end

    always @(posedge MCLK or posedge RST) begin
        if (RST) begin
            power_fail_decel_reg <= 1'b0;
        end else begin
            power_fail_decel_reg <= power_fail_decel_next;
        end
    end

    // The terminal decode indexes this vector, so its bit order must not change.
    assign cond_vec = {loop_active_reg, power_fail_decel_reg, heatsink_prealarm_reg,
                       fan_fault_reg, brake_open_request_reg, loop_direction_out_reg,
                       loop_upper_limit_reg, loop_lower_limit_reg, zero_current_detect_reg,
                       current_detect_reg, operation_ready_reg, thermal_prealarm_reg,
                       regen_brake_prealarm_reg, freq_detect_reg, overload_alarm_reg,
                       freq_reached_reg, run_reg};

    assign COND_STATE = cond_vec;

    // Terminal 0 is the physical output, 1..5 the link virtual outputs.
    genvar gi;
    generate
        for (gi = 0; gi < `OSS_NUM_TERM; gi = gi + 1) begin : g_term
            oss_term_sel u_sel (
                .clk      (MCLK),
                .rst      (RST),
                .sel_code (sel_all[gi*14 +: 14]),
                .cond     (cond_vec),
                .term_on  (term_on[gi])
            );
        end
    endgenerate

    assign OPEN_COLLECTOR_OUTPUT = term_on[`OSS_ZERO_TERM];
    assign LINK_OUT              = term_on[5:1];
endmodule
`default_nettype wire

//--- verification/oss_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module oss_ctrl_model (
    input  wire logic       oc_on,
    input  wire logic [4:0] link_bits,
    output logic            line_level,
    output logic [4:0]      seen_bits
);
    // The open-collector line has a pull-up, so a conducting terminal reads low.
    assign line_level = oc_on ? 1'b0 : 1'b1;
    assign seen_bits  = link_bits;
endmodule
`default_nettype wire

//--- verification/oss_selector_sva.sv
`timescale 1ns/1ps
`default_nettype none
module oss_selector_sva (
    input wire logic        MCLK,
    input wire logic        RST,
    input wire logic [13:0] SEL_CODE_0,
    input wire logic [13:0] SEL_CODE_1,
    input wire logic [15:0] OUT_FREQ,
    input wire logic [15:0] START_FREQ,
    input wire logic        STALL_ACTIVE,
    input wire logic [7:0]  THERMAL_PCT,
    input wire logic        PF_DECEL_RUN,
    input wire logic        OPEN_COLLECTOR_OUTPUT,
    input wire logic [4:0]  LINK_OUT,
    input wire logic        THERMAL_TRIP_FAULT,
    input wire logic [16:0] COND_STATE
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (RST);
    sequence run_on_oc;
        OUT_FREQ >= START_FREQ && SEL_CODE_0 == 14'h0 ##1 SEL_CODE_0 == 14'h0;
    endsequence
    chk_run_cond: assert property (OUT_FREQ >= START_FREQ |=> COND_STATE[0])
        else $error("running flag missing");
    chk_stall_flag: assert property (STALL_ACTIVE |=> COND_STATE[2])
        else $error("overload flag missing");
    chk_thp_level: assert property (THERMAL_PCT >= 8'h55 |=> COND_STATE[5])
        else $error("thermal pre-alarm missing");
    chk_trip_set: assert property (THERMAL_PCT >= 8'h64 |-> ##[1:2] THERMAL_TRIP_FAULT)
        else $error("thermal trip missing");
    chk_trip_sticky: assert property (THERMAL_TRIP_FAULT |=> THERMAL_TRIP_FAULT)
        else $error("thermal trip dropped");
    chk_pfd_set: assert property ($rose(PF_DECEL_RUN) |=> COND_STATE[15])
        else $error("power-fail flag missing");
    chk_oc_follow: assert property (run_on_oc |=> OPEN_COLLECTOR_OUTPUT)
        else $error("terminal not conducting");
    chk_neg_block: assert property (SEL_CODE_1 == 14'h64 && COND_STATE[0] |=> !LINK_OUT[0])
        else $error("negative output conducting");
endmodule
bind oss_selector oss_selector_sva i_oss_selector_sva (.*);
`default_nettype wire

//--- verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        MCLK = 1'b0;
    logic        RST = 1'b1;
    logic [13:0] SEL_CODE_0 = 14'h0, SEL_CODE_1 = 14'h64, SEL_CODE_2 = 14'hc;
    logic [13:0] SEL_CODE_3 = 14'hc8, SEL_CODE_4 = 14'h270f, SEL_CODE_5 = 14'h0;
    logic [15:0] OUT_FREQ = 16'h0, START_FREQ = 16'h10, SET_FREQ = 16'h100, FREQ_TOL = 16'h4;
    logic [15:0] FDET_FWD_LEVEL = 16'h80, FDET_REV_LEVEL = 16'h40, OUT_CURRENT = 16'h0;
    logic [15:0] IDET_LEVEL = 16'h50, IDET_TIME = 16'h8, OUT_POWER = 16'hff, ZDET_LEVEL = 16'h10;
    logic [15:0] ZDET_TIME = 16'h8, LOOP_FEEDBACK = 16'h50, LOOP_LOW_LIMIT = 16'h20;
    logic [15:0] LOOP_HIGH_LIMIT = 16'h80;
    logic [7:0]  REGEN_DUTY_PCT = 8'h0, THERMAL_PCT = 8'h0, HEATSINK_PCT = 8'h0;
    logic        REVERSE = 1'b0, STALL_ACTIVE = 1'b0, RESET_DONE = 1'b1, STARTABLE = 1'b1;
    logic        LOOP_ENABLE = 1'b0, LOOP_FORWARD = 1'b0, BRAKE_SEQ_EN = 1'b0;
    logic        BRAKE_OPEN_CMD = 1'b0, FAN_FAULT = 1'b0, PF_DECEL_RUN = 1'b0, PF_RELEASE = 1'b0;
    wire logic        OPEN_COLLECTOR_OUTPUT, THERMAL_TRIP_FAULT, line_level;
    wire logic [4:0]  LINK_OUT, seen_bits;
    wire logic [16:0] COND_STATE;
    int          bad_count = 0, samples_checked = 0;
    logic [7:0]  codes [17] = '{8'h0, 8'h1, 8'h3, 8'h4, 8'h7, 8'h8, 8'hb, 8'hc, 8'hd,
                                8'he, 8'hf, 8'h10, 8'h14, 8'h19, 8'h1a, 8'h2e, 8'h2f};
    always #2.5 MCLK = ~MCLK;
    oss_selector i_oss_selector (.*);
    oss_ctrl_model i_oss_ctrl_model (.oc_on(OPEN_COLLECTOR_OUTPUT), .link_bits(LINK_OUT),
                                     .line_level(line_level), .seen_bits(seen_bits));
    task automatic cmp(input logic [16:0] got, input logic [16:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    // Two edges cover both register stages from input to terminal.
    task automatic cc(input logic [16:0] exp);
        repeat (2) @(negedge MCLK);
        cmp(COND_STATE, exp);
    endtask
    task automatic ct(input logic [5:0] exp);
        cmp({11'h0, ~line_level, seen_bits}, {11'h0, exp});
    endtask
    task automatic complete_run;
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(negedge MCLK);
        RST = 1'b0;
        cc(17'h00040);
        ct(6'h01);
        foreach (codes[i]) begin
            SEL_CODE_0 = {6'h0, codes[i]};
            repeat (2) @(negedge MCLK);
            cmp({16'h0, OPEN_COLLECTOR_OUTPUT}, {16'h0, codes[i] == 8'hb});
            SEL_CODE_0 = {6'h0, codes[i]} + 14'h64;
            repeat (2) @(negedge MCLK);
            cmp({16'h0, OPEN_COLLECTOR_OUTPUT}, {16'h0, codes[i] != 8'hb});
        end
        SEL_CODE_0 = 14'h69;
        repeat (2) @(negedge MCLK);
        cmp({16'h0, OPEN_COLLECTOR_OUTPUT}, 17'h0);
        SEL_CODE_0 = 14'h0;
        OUT_FREQ = 16'h104;
        cc(17'h0004b);
        ct(6'h30);
        REVERSE = 1'b1;
        OUT_FREQ = 16'h50;
        START_FREQ = 16'h51;
        cc(17'h00048);
        STALL_ACTIVE = 1'b1;
        FAN_FAULT = 1'b1;
        HEATSINK_PCT = 8'h55;
        REGEN_DUTY_PCT = 8'h54;
        THERMAL_PCT = 8'h64;
        cc(17'h0606c);
        THERMAL_PCT = 8'h0;
        OUT_CURRENT = 16'h60;
        OUT_POWER = 16'h0;
        cc(17'h0604c);
        repeat (12) @(negedge MCLK);
        cc(17'h061cc);
        cmp({16'h0, THERMAL_TRIP_FAULT}, 17'h1);
        ct(6'h03);
        LOOP_ENABLE = 1'b1;
        LOOP_FORWARD = 1'b1;
        LOOP_FEEDBACK = 16'h10;
        BRAKE_SEQ_EN = 1'b1;
        REGEN_DUTY_PCT = 8'h55;
        cc(17'h16bdc);
        LOOP_HIGH_LIMIT = 16'h8;
        BRAKE_OPEN_CMD = 1'b1;
        PF_DECEL_RUN = 1'b1;
        @(negedge MCLK);
        PF_DECEL_RUN = 1'b0;
        cc(17'h1ffdc);
        PF_RELEASE = 1'b1;
        RESET_DONE = 1'b0;
        STARTABLE = 1'b0;
        cc(17'h17f9c);
        ct(6'h02);
        complete_run();
    end
endmodule
`default_nettype wire
